// ### rtl/scm_pkg.sv
// Package for the SRAM host controller: pin widths, phase timing and states.
// Assumes a 40 MHz mclk and a 16K x 1 asynchronous SRAM with separate data pins.
package scm_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W = 14;
  localparam int DEPTH  = 16384;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS   = 25000;
  // Longest access time of the slowest grade, in ps, as a least wait.
  localparam int ACCESS_PS       = 35000;
  // Least write strobe low width, in ps.
  localparam int WRITE_LOW_PS    = 25000;
  // Longest power down delay of the slowest grade, in ps.
  localparam int POWER_DOWN_DELAY_PS = 35000;
  localparam int ACCESS_CYC   = (ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_CYC    = (WRITE_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PD_CYC_RAW   = POWER_DOWN_DELAY_PS / CLK_PERIOD_PS;
  localparam int PD_CYC       = (PD_CYC_RAW < 1) ? 1 : PD_CYC_RAW;
  localparam int CNT_W        = 4;
  localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC);
  localparam logic [CNT_W-1:0] WRITE_CNT  = CNT_W'(WRITE_CYC);
  localparam logic [CNT_W-1:0] PD_CNT     = CNT_W'(PD_CYC);
  // Read data crosses two synchroniser flops, so the read wait covers them too.
  localparam int SYNC_STAGES = 2;
  localparam logic [CNT_W-1:0] READ_CNT   = CNT_W'(ACCESS_CYC + SYNC_STAGES);
  localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;
  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    SCM_IDLE  = 3'b000,
    SCM_SETUP = 3'b001,
    SCM_WLOW  = 3'b010,
    SCM_WEND  = 3'b011,
    SCM_RWAIT = 3'b100,
    SCM_DONE  = 3'b101
  } scm_state_e;
endpackage : scm_pkg

// ### rtl/scm_sync.sv
// Two-stage synchroniser for one level coming from an SRAM pin.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module scm_sync (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  // First stage feeds only the second stage.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : scm_sync
`default_nettype wire

// ### rtl/scm_host.sv
// Host controller that drives a 16K x 1 asynchronous SRAM through its pins.
// Assumes one request at a time from on-chip logic on mclk, and a device pin set.
// Notes on behaviour
// - Writes happen only while select and write strobe are both low.
// - Write ends when select or strobe rises; setup and hold cover both edges.
// - Address changes only while select or strobe is high.
// - Write strobe stays high through every read.
`timescale 1ns/100ps
`default_nettype none
module scm_host
  import scm_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic              req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic                   rsp_rdata,
  output logic                   device_active,
  output logic [ADDR_W-1:0]      sram_addr,
  output logic                   sram_din,
  output logic                   sram_sel_n,
  output logic                   sram_we_n,
  input  wire logic              sram_dout,
  input  wire logic              sram_dout_oe
);
  // ****************************************
  // State and registers
  // ****************************************
  scm_state_e              state_q, state_d;
  logic [CNT_W-1:0]        cnt_q, cnt_d;
  logic [CNT_W-1:0]        pd_q, pd_d;
  logic                    wr_q;
  logic [ADDR_W-1:0]       addr_q;
  logic                    din_q;
  logic                    sel_n_q, sel_n_d;
  logic                    we_n_q, we_n_d;
  logic                    rdata_q;
  logic                    rsp_q;
  logic                    dout_s;
  logic                    dout_oe_s;
  wire                     take    = (state_q == SCM_IDLE) && req_valid;
  wire                     cnt_end = (cnt_q == CNT_ONE);
  // select falling, or strobe falling while selected, wakes the device.
  wire                     wake    = (sel_n_q && !sel_n_d) || (!sel_n_d && we_n_q && !we_n_d);

  // Pin data from the device is asynchronous, so it is synchronised first.
  scm_sync u_sync_dout (
    .mclk (mclk),
    .rstn (rstn),
    .d    (sram_dout),
    .q    (dout_s)
  );
  scm_sync u_sync_oe (
    .mclk (mclk),
    .rstn (rstn),
    .d    (sram_dout_oe),
    .q    (dout_oe_s)
  );

  // ****************************************
  // Next-state decode
  // ****************************************
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sel_n_d = sel_n_q;
    we_n_d  = we_n_q;
    unique case (state_q)
      SCM_IDLE: begin
        if (req_valid) begin
          state_d = SCM_SETUP;
        end
      end
      SCM_SETUP: begin
        // strobe falls with select on writes.
        sel_n_d = 1'b0;
        if (wr_q) begin
          we_n_d  = 1'b0;
          cnt_d   = WRITE_CNT;
          state_d = SCM_WLOW;
        end else begin
          we_n_d  = 1'b1;
          // The wait spans the access time and the synchroniser delay, so the
          // sampled bit is the one the device drove after its access time.
          cnt_d   = READ_CNT;
          state_d = SCM_RWAIT;
        end
      end
      SCM_WLOW: begin
        cnt_d = cnt_q - CNT_ONE;
        if (cnt_end) begin
          sel_n_d = 1'b1;
          state_d = SCM_WEND;
        end
      end
      SCM_WEND: begin
        // data held past the write end.
        we_n_d  = 1'b1;
        state_d = SCM_DONE;
      end
      SCM_RWAIT: begin
        cnt_d = cnt_q - CNT_ONE;
        if (cnt_end) begin
          sel_n_d = 1'b1;
          state_d = SCM_DONE;
        end
      end
      SCM_DONE: begin
        state_d = SCM_IDLE;
      end
      default: begin
        state_d = SCM_IDLE;
        sel_n_d = 1'b1;
        we_n_d  = 1'b1;
      end
    endcase
  end

  // power-down delay tracker, restarted by each wake event.
  always_comb begin
    if (wake || (state_q == SCM_SETUP)) begin
      pd_d = PD_CNT;
    end else if (pd_q != CNT_ZERO) begin
      pd_d = pd_q - CNT_ONE;
    end else begin
      pd_d = pd_q;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SCM_IDLE;
      cnt_q   <= CNT_ZERO;
      pd_q    <= CNT_ZERO;
      sel_n_q <= 1'b1;
      we_n_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pd_q    <= pd_d;
      sel_n_q <= sel_n_d;
      we_n_q  <= we_n_d;
    end
  end

  // Request capture; address and data stay put until the next request.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_q   <= 1'b0;
      addr_q <= '0;
      din_q  <= 1'b0;
    end else if (take) begin
      wr_q   <= req_write;
      addr_q <= req_addr;
      din_q  <= req_wdata;
    end
  end

  // read bit sampled at the end of the access, no inversion.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 1'b0;
      rsp_q   <= 1'b0;
    end else begin
      rsp_q <= (state_q == SCM_RWAIT) && cnt_end;
      if ((state_q == SCM_RWAIT) && cnt_end) begin
        rdata_q <= dout_s & dout_oe_s;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // write interval is the overlap of both lows.
  assign sram_sel_n    = sel_n_q;
  assign sram_we_n     = we_n_q;
  assign sram_addr     = addr_q;
  assign sram_din      = din_q;
  assign req_ready     = (state_q == SCM_IDLE);
  assign rsp_valid     = rsp_q;
  assign rsp_rdata     = rdata_q;
  assign device_active = (pd_q != CNT_ZERO);
endmodule : scm_host
`default_nettype wire

// ### verification/scm_sram_model.sv
// Behavioural 16K x 1 SRAM with separate data pins, far side of the host.
// Assumes the host drives select, strobe, address and data-in as levels.
`timescale 1ns/100ps
`default_nettype none
module scm_sram_model
  import scm_pkg::*;
(
  input  wire logic [ADDR_W-1:0] sram_addr,
  input  wire logic              sram_din,
  input  wire logic              sram_sel_n,
  input  wire logic              sram_we_n,
  output logic                   sram_dout,
  output logic                   sram_dout_oe
);
  logic mem [DEPTH];
  logic last_q = 1'h0;
  always @(*) begin
    if (!sram_sel_n && !sram_we_n)
      mem[sram_addr] = sram_din;
  end
  assign sram_dout_oe = !sram_sel_n && sram_we_n;
  always @(*) begin
    if (sram_dout_oe)
      last_q = mem[sram_addr];
  end
  // A released pin shows the inverse, so stale data never passes for a read.
  assign sram_dout = sram_dout_oe ? mem[sram_addr] : !last_q;
endmodule : scm_sram_model
`default_nettype wire

// ### verification/scm_host_sva.sv
// Checker for the SRAM host pin sequences and handshake.
// Assumes it is bound to scm_host and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module scm_host_sva
  import scm_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic              req_valid,
  input wire logic              req_write,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic              device_active,
  input wire logic [ADDR_W-1:0] sram_addr,
  input wire logic              sram_din,
  input wire logic              sram_sel_n,
  input wire logic              sram_we_n
);
  // One clock domain, so one default clock and reset guard.
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // Write: one cycle of overlap, then select rises before the strobe.
  sequence wr_walk_s;
    (sram_sel_n && sram_we_n) ##1 (!sram_sel_n && !sram_we_n)
      ##1 (sram_sel_n && !sram_we_n) ##1 (sram_sel_n && sram_we_n) ##1 req_ready;
  endsequence
  // Read: select low for the access time plus the synchroniser delay.
  sequence rd_walk_s;
    (sram_sel_n && sram_we_n) ##1 (!sram_sel_n && sram_we_n) [*4]
      ##1 (sram_sel_n && rsp_valid) ##1 req_ready;
  endsequence
  a_write_walk: assert property (req_valid && req_ready && req_write |=> wr_walk_s)
    else $error("write pin sequence wrong");
  a_read_walk: assert property (req_valid && req_ready && !req_write |=> rd_walk_s)
    else $error("read pin sequence wrong");
  a_read_strobe_high: assert property (req_valid && req_ready && !req_write |=> sram_we_n [*6])
    else $error("strobe low in read");
  a_addr_move_safe: assert property (!$stable(sram_addr) |->
    (sram_sel_n || sram_we_n) && ($past(sram_sel_n) || $past(sram_we_n)))
    else $error("address moved during write");
  a_write_data_hold: assert property (!sram_sel_n && !sram_we_n |-> $stable(sram_din))
    else $error("data moved during write");
  a_select_rises_first: assert property ($rose(sram_we_n) |-> $past(sram_sel_n))
    else $error("strobe rose before select");
  a_rsp_from_read: assert property (rsp_valid |-> !$past(sram_sel_n) && sram_we_n)
    else $error("response without read");
  a_wake_on_select: assert property ($fell(sram_sel_n) |-> ##[0:2] device_active)
    else $error("no wake on select");
  a_sleep_when_idle: assert property (sram_sel_n [*4] |-> !device_active)
    else $error("no power down when idle");
endmodule : scm_host_sva
bind scm_host scm_host_sva scm_host_sva_i (
  .mclk          (mclk),
  .rstn          (rstn),
  .req_valid     (req_valid),
  .req_write     (req_write),
  .req_ready     (req_ready),
  .rsp_valid     (rsp_valid),
  .device_active (device_active),
  .sram_addr     (sram_addr),
  .sram_din      (sram_din),
  .sram_sel_n    (sram_sel_n),
  .sram_we_n     (sram_we_n)
);
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the SRAM host controller.
// Assumes the SRAM model answers on the far side of the host.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import scm_pkg::*;
;
  typedef struct packed {logic wr; logic [ADDR_W-1:0] a; logic d;} scm_row_s;
  logic              mclk = 1'h0, rstn = 1'h0, req_valid = 1'h0, req_write = 1'h0;
  logic              req_wdata = 1'h0;
  logic [ADDR_W-1:0] req_addr = '0, sram_addr;
  logic              req_ready, rsp_valid, rsp_rdata, device_active, sram_din;
  logic              sram_sel_n, sram_we_n, sram_dout, sram_dout_oe;
  int                n_fail = 0, checks_done = 0, cycles = 0;
  // Rows: write flag, address, data or expected read bit; back-to-back order.
  scm_row_s rows [9] = '{{1'h1, 14'h0000, 1'h1}, {1'h1, 14'h3FFF, 1'h1},
    {1'h1, 14'h1555, 1'h0}, {1'h1, 14'h0000, 1'h0}, {1'h0, 14'h0000, 1'h0},
    {1'h1, 14'h2AAA, 1'h1}, {1'h0, 14'h2AAA, 1'h1}, {1'h0, 14'h3FFF, 1'h1},
    {1'h0, 14'h1555, 1'h0}};
  scm_host scm_host_i (
    .mclk          (mclk),
    .rstn          (rstn),
    .req_valid     (req_valid),
    .req_write     (req_write),
    .req_addr      (req_addr),
    .req_wdata     (req_wdata),
    .req_ready     (req_ready),
    .rsp_valid     (rsp_valid),
    .rsp_rdata     (rsp_rdata),
    .device_active (device_active),
    .sram_addr     (sram_addr),
    .sram_din      (sram_din),
    .sram_sel_n    (sram_sel_n),
    .sram_we_n     (sram_we_n),
    .sram_dout     (sram_dout),
    .sram_dout_oe  (sram_dout_oe)
  );
  scm_sram_model scm_sram_model_i (
    .sram_addr    (sram_addr),
    .sram_din     (sram_din),
    .sram_sel_n   (sram_sel_n),
    .sram_we_n    (sram_we_n),
    .sram_dout    (sram_dout),
    .sram_dout_oe (sram_dout_oe)
  );
  initial forever #12.5 mclk = ~mclk;
  // Hang guard; the tests need well under a few hundred cycles.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(string name, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk
  // Hold the request until taken, then wait for the answer under a bound.
  task automatic op(scm_row_s r);
    int n;
    req_valid = 1'h1;
    req_write = r.wr;
    req_addr = r.a;
    req_wdata = r.d;
    for (n = 0; n < 20 && !req_ready; n++) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'h0;
    for (n = 0; n < 20 && !(r.wr ? req_ready : rsp_valid); n++) @(negedge mclk);
    // A missing answer counts as a mismatch instead of passing silently.
    chk(r.wr ? "req_ready" : "rsp_valid", 1'h1, r.wr ? req_ready : rsp_valid);
    if (!r.wr) chk("rsp_rdata", r.d, rsp_rdata);
  endtask : op
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(negedge mclk);
    chk("sram_sel_n", 1'h1, sram_sel_n);
    chk("sram_we_n", 1'h1, sram_we_n);
    chk("device_active", 1'h0, device_active);
    rstn = 1'h1;
    $display("test reset done");
    foreach (rows[i]) op(rows[i]);
    $display("test rows done");
    repeat (4) @(negedge mclk);
    chk("device_active", 1'h0, device_active);
    // Abort a write in its overlap; the pins must let go at once.
    req_write = 1'h1;
    req_addr = 14'h1555;
    req_valid = 1'h1;
    @(negedge mclk);
    req_valid = 1'h0;
    @(negedge mclk);
    chk("sram_we_n", 1'h0, sram_we_n);
    rstn = 1'h0;
    @(posedge mclk);
    chk("sram_sel_n", 1'h1, sram_sel_n);
    chk("sram_we_n", 1'h1, sram_we_n);
    @(negedge mclk);
    rstn = 1'h1;
    op({1'h0, 14'h0000, 1'h0});
    $display("test abort done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
